// file: pcie_pkg.sv
// Purpose: shared constants for the socket interrupt event block
// Assumes: one socket per instance, 8-bit register fields in low bits
// Notes:   offsets are per address space selected by regSpace
package pcie_pkg;
    // address space selector
    localparam logic [1:0] SPACE_CARD   = 2'h0;  // 16-bit card register set
    localparam logic [1:0] SPACE_CONFIG = 2'h1;  // configuration space
    localparam logic [1:0] SPACE_SOCKET = 2'h2;  // socket register block
    // register offsets
    localparam logic [7:0] OFS_GEN_INT_CTL   = 8'h03;
    localparam logic [7:0] OFS_STAT_FLAGS    = 8'h04;
    localparam logic [7:0] OFS_STAT_CFG      = 8'h05;
    localparam logic [7:0] OFS_IO_OFS_HIGH   = 8'h1E;
    localparam logic [7:0] OFS_CARD_CTL      = 8'h91;
    localparam logic [7:0] OFS_DEV_CTL       = 8'h92;
    localparam logic [7:0] OFS_SOCK_EVENT    = 8'h00;
    localparam logic [7:0] OFS_SOCK_MASK     = 8'h04;
    localparam logic [7:0] OFS_SOCK_PRESENT  = 8'h08;
    // 16-bit flag / config bit positions
    localparam int BIT_BVD_ONE   = 0;
    localparam int BIT_BVD_TWO   = 1;
    localparam int BIT_READY     = 2;
    localparam int BIT_DETECT    = 3;
    localparam int BIT_CARD_IO   = 5;  // card is I/O type, in general control
    localparam int BIT_CLR_W1C   = 2;  // flag clear by write-one, in io offset high
    // socket event / mask bit positions
    localparam int BIT_CB_STATUS = 0;
    localparam int BIT_CD_ONE    = 1;
    localparam int BIT_CD_TWO    = 2;
    localparam int BIT_PWR_DONE  = 3;
    localparam int BIT_CB_IRQ    = 6;  // present state
    // card control bit positions
    localparam int BIT_FUNC_PEND = 0;
    localparam int BIT_CHG_EN    = 3;
    localparam int BIT_FUNC_EN   = 4;
    localparam int BIT_PCI_EN    = 5;
    localparam logic [7:0] CARD_CTL_WMASK = 8'h38;
    // signaling mode in device control bits 2..1
    localparam int MODE_LSB = 1;
    localparam logic [1:0] MODE_ISA    = 2'b01;
    localparam logic [1:0] MODE_SERIAL = 2'b10;
    // isa pins and reset values
    localparam int NUM_ISA_PINS = 10;
    localparam logic [7:0] RST_BYTE = 8'h00;
endpackage

// file: pcie_events.sv
// Purpose: per-socket card event flags, masks and interrupt routing
// Assumes: all inputs synchronous to core_clk; card lines as seen at pins
// Notes:   pin outputs are registered; pin PCI_PIN (0 or 1) doubles as the PCI line

`timescale 1ns/100ps

// Function
// [RQ1] memory card battery line change flags bits 1:0
// [RQ2] memory card ready change flags bit 2
// [RQ3] io status-change assertion flags bit 0
// [RQ4] io card request is unmasked functional interrupt
// [RQ5] cardbus status-change sets socket event bit 0
// [RQ6] cardbus interrupt shown in present-state bit 6
// [RQ7] power-up complete sets socket event bit 3
// [RQ8] card detect change flags event and bit 3
// [RQ9] power-up event comes from internal power sequencer
// [RQ10] status-change and functional routed separately
// [RQ11] every source has a readable flag
// [RQ12] 16-bit flags clear by read or write-one
// [RQ13] cardbus flags clear only by write-one
// [RQ14] pci mode enables from card control bits
// [RQ15] isa outputs only for ten irq numbers
// [RQ16] device control 01b selects isa outputs
// [RQ17] isa pins float until routing is valid
// [RQ18] routing from config upper, general control lower nibble
// [RQ19] software masks and reroutes on card change
// [RQ20] software uses read-modify-write on registers
// [RQ21] pci line open-drain on shared irq pin
// [RQ22] pci line usable together with isa pins
// [RQ23] device control 10b selects serialized levels
// [RQ24] card control enables pci mode and routes
// [RQ25] output follows any routed unmasked pending flag
module pcie_events #(
    parameter int PCI_PIN = 0  // 0: socket A on IRQ3 pin, 1: socket B on IRQ4 pin
) (
    // clock and reset
    input  wire logic        core_clk,
    input  wire logic        rstn,
    // register port
    input  wire logic        regWrite,
    input  wire logic        regRead,
    input  wire logic [1:0]  regSpace,
    input  wire logic [7:0]  regAddr,
    input  wire logic [31:0] regWdata,
    output logic      [31:0] regRdata,
    // card side lines
    input  wire logic        cardIsCardbus,
    input  wire logic        battery_detect_one,
    input  wire logic        battery_detect_two,
    input  wire logic        cardReady,
    input  wire logic        card_status_change_n,
    input  wire logic        card_irq_request_n,
    input  wire logic        cb_status_change_line,
    input  wire logic        cb_irq_request_n,
    input  wire logic        card_detect_one_n,
    input  wire logic        card_detect_two_n,
    // internal power sequencer
    input  wire logic        powerUpDone,
    // interrupt pins
    output logic [9:0]       irqOut,
    output logic [9:0]       irqOe,
    output logic [15:0]      serialIrqLevel
);

    // one-hot isa pin for an irq number, zero when not a pin
    function automatic logic [9:0] irqOneHot(input logic [3:0] n);
        logic [9:0] r;
        r = '0;
        case (n)
            4'h3:    r = 10'h001;
            4'h4:    r = 10'h002;
            4'h5:    r = 10'h004;
            4'h7:    r = 10'h008;
            4'h9:    r = 10'h010;
            4'hA:    r = 10'h020;
            4'hB:    r = 10'h040;
            4'hC:    r = 10'h080;
            4'hE:    r = 10'h100;
            4'hF:    r = 10'h200;
            default: r = '0;
        endcase
        return r;
    endfunction

    // registers
    logic [7:0]  genCtl_q, genCtl_d;        // routing nibble, card type
    logic [3:0]  statFlags_q, statFlags_d;  // 16-bit card flags
    logic [7:0]  statCfg_q, statCfg_d;      // masks and chg routing
    logic [7:0]  ioOfsHigh_q, ioOfsHigh_d;  // clear method select
    logic [7:0]  cardCtl_q, cardCtl_d;      // pci enables
    logic [7:0]  devCtl_q, devCtl_d;        // signaling mode
    logic [3:0]  sockEvent_q, sockEvent_d;  // cardbus event flags
    logic [3:0]  sockMask_q, sockMask_d;    // cardbus masks
    // line history for edge detection
    logic [6:0]  linePrev_q, lineNow;
    logic        primed_q;
    // pin and read outputs
    logic [31:0] regRdata_q, regRdata_d;
    logic [9:0]  irqOut_q, irqOut_d, irqOe_q, irqOe_d;
    logic [15:0] serial_q, serial_d;
    // decoded terms
    logic        wrCard, rdCard, wrCfg, wrSock, isIo, funcPend, chgPend;
    logic [6:0]  chg;
    logic [3:0]  flagSet, evSet;
    logic [1:0]  mode;
    logic [9:0]  chgPin, funcPin, isaLevels;
    logic        fieldsOk, pciAssert;

    assign regRdata       = regRdata_q;
    assign irqOut         = irqOut_q;
    assign irqOe          = irqOe_q;
    assign serialIrqLevel = serial_q;

    // event detection, flags and register writes
    always_comb begin
        lineNow = {powerUpDone, card_detect_two_n, card_detect_one_n, cb_status_change_line,
                   cardReady, battery_detect_two, battery_detect_one};
        chg     = primed_q ? (lineNow ^ linePrev_q) : '0;
        wrCard  = regWrite && (regSpace == pcie_pkg::SPACE_CARD);
        rdCard  = regRead && (regSpace == pcie_pkg::SPACE_CARD);
        wrCfg   = regWrite && (regSpace == pcie_pkg::SPACE_CONFIG);
        wrSock  = regWrite && (regSpace == pcie_pkg::SPACE_SOCKET);
        isIo    = genCtl_q[pcie_pkg::BIT_CARD_IO];
        mode    = devCtl_q[pcie_pkg::MODE_LSB +: 2];
        flagSet = '0;
        evSet   = '0;
        // 16-bit sources
        if (!cardIsCardbus && !isIo) begin
            flagSet[pcie_pkg::BIT_BVD_ONE] = chg[0];  // RQ1
            flagSet[pcie_pkg::BIT_BVD_TWO] = chg[1];  // RQ1
            flagSet[pcie_pkg::BIT_READY]   = chg[2];  // RQ2
        end else if (!cardIsCardbus) begin
            // assertion of the active-low status line
            flagSet[pcie_pkg::BIT_BVD_ONE] = chg[0] && !battery_detect_one;  // RQ3
        end
        flagSet[pcie_pkg::BIT_DETECT] = chg[4] || chg[5];  // RQ8
        // cardbus and card-independent sources
        if (cardIsCardbus) begin
            evSet[pcie_pkg::BIT_CB_STATUS] = chg[3] && cb_status_change_line;  // RQ5
        end
        evSet[pcie_pkg::BIT_CD_ONE]   = chg[4];  // RQ8
        evSet[pcie_pkg::BIT_CD_TWO]   = chg[5];  // RQ8
        evSet[pcie_pkg::BIT_PWR_DONE] = powerUpDone && !linePrev_q[6];  // RQ7 RQ9
        // 16-bit flags: read clears or write-one clears, set wins
        statFlags_d = statFlags_q;
        if (rdCard && regAddr == pcie_pkg::OFS_STAT_FLAGS
            && !ioOfsHigh_q[pcie_pkg::BIT_CLR_W1C]) begin
            statFlags_d = '0;  // RQ12
        end else if (wrCard && regAddr == pcie_pkg::OFS_STAT_FLAGS
                     && ioOfsHigh_q[pcie_pkg::BIT_CLR_W1C]) begin
            statFlags_d = statFlags_q & ~regWdata[3:0];  // RQ12
        end
        statFlags_d = statFlags_d | flagSet;  // RQ11
        // cardbus events: write-one only, reads leave them
        sockEvent_d = sockEvent_q;
        if (wrSock && regAddr == pcie_pkg::OFS_SOCK_EVENT) begin
            sockEvent_d = sockEvent_q & ~regWdata[3:0];  // RQ13
        end
        sockEvent_d = sockEvent_d | evSet;  // RQ11
        // plain read/write registers
        genCtl_d    = (wrCard && regAddr == pcie_pkg::OFS_GEN_INT_CTL) ? regWdata[7:0] : genCtl_q;
        statCfg_d   = (wrCard && regAddr == pcie_pkg::OFS_STAT_CFG) ? regWdata[7:0] : statCfg_q;
        ioOfsHigh_d = (wrCard && regAddr == pcie_pkg::OFS_IO_OFS_HIGH) ? regWdata[7:0]
                                                                       : ioOfsHigh_q;
        cardCtl_d   = (wrCfg && regAddr == pcie_pkg::OFS_CARD_CTL)
                      ? (regWdata[7:0] & pcie_pkg::CARD_CTL_WMASK) : cardCtl_q;
        devCtl_d    = (wrCfg && regAddr == pcie_pkg::OFS_DEV_CTL) ? regWdata[7:0] : devCtl_q;
        sockMask_d  = (wrSock && regAddr == pcie_pkg::OFS_SOCK_MASK) ? regWdata[3:0]
                                                                     : sockMask_q;
    end

    // pending terms and pin drive
    always_comb begin
        // functional request: level, no mask
        funcPend = cardIsCardbus ? !cb_irq_request_n
                                 : (isIo && !card_irq_request_n);  // RQ4 RQ6
        chgPend  = |(statFlags_q & statCfg_q[3:0]) | |(sockEvent_q & sockMask_q);  // RQ25
        chgPin   = irqOneHot(statCfg_q[7:4]);  // RQ18
        funcPin  = irqOneHot(genCtl_q[3:0]);   // RQ18
        // each field is empty or a pin number, and one routes somewhere
        fieldsOk = (statCfg_q[7:4] == '0 || chgPin != '0)
                && (genCtl_q[3:0] == '0 || funcPin != '0)
                && (chgPin != '0 || funcPin != '0);  // RQ15 RQ17
        isaLevels = (chgPend ? chgPin : '0) | (funcPend ? funcPin : '0);  // RQ10 RQ25
        irqOut_d  = '0;
        irqOe_d   = '0;
        if (mode == pcie_pkg::MODE_ISA && fieldsOk) begin
            irqOut_d = isaLevels;  // RQ16
            irqOe_d  = '1;         // RQ17
        end
        // pci line overrides its shared pin, others stay isa
        pciAssert = (cardCtl_q[pcie_pkg::BIT_CHG_EN] && chgPend)
                 || (cardCtl_q[pcie_pkg::BIT_FUNC_EN] && funcPend);  // RQ14 RQ24
        if (cardCtl_q[pcie_pkg::BIT_PCI_EN]) begin
            irqOut_d[PCI_PIN] = 1'b0;       // RQ21 RQ22
            irqOe_d[PCI_PIN]  = pciAssert;  // RQ21
        end
        // serialized mode hands levels to the frame generator
        serial_d = '0;
        if (mode == pcie_pkg::MODE_SERIAL) begin
            serial_d = ((chgPend && statCfg_q[7:4] != '0) ? 16'h0001 << statCfg_q[7:4] : '0)
                     | ((funcPend && genCtl_q[3:0] != '0) ? 16'h0001 << genCtl_q[3:0] : '0);  // RQ23
        end
    end

    // read data mux, answered one cycle after the strobe
    always_comb begin
        regRdata_d = regRdata_q;
        if (regRead) begin
            regRdata_d = '0;
            case (regSpace)
                pcie_pkg::SPACE_CARD: begin
                    case (regAddr)
                        pcie_pkg::OFS_GEN_INT_CTL: regRdata_d[7:0] = genCtl_q;
                        pcie_pkg::OFS_STAT_FLAGS:  regRdata_d[3:0] = statFlags_q;  // RQ11
                        pcie_pkg::OFS_STAT_CFG:    regRdata_d[7:0] = statCfg_q;
                        pcie_pkg::OFS_IO_OFS_HIGH: regRdata_d[7:0] = ioOfsHigh_q;
                        default:                   regRdata_d = '0;
                    endcase
                end
                pcie_pkg::SPACE_CONFIG: begin
                    case (regAddr)
                        pcie_pkg::OFS_CARD_CTL: begin
                            regRdata_d[7:0] = cardCtl_q;
                            regRdata_d[pcie_pkg::BIT_FUNC_PEND] = funcPend;  // RQ11
                        end
                        pcie_pkg::OFS_DEV_CTL: regRdata_d[7:0] = devCtl_q;
                        default:               regRdata_d = '0;
                    endcase
                end
                pcie_pkg::SPACE_SOCKET: begin
                    case (regAddr)
                        pcie_pkg::OFS_SOCK_EVENT: regRdata_d[3:0] = sockEvent_q;  // RQ13
                        pcie_pkg::OFS_SOCK_MASK:  regRdata_d[3:0] = sockMask_q;
                        pcie_pkg::OFS_SOCK_PRESENT: begin
                            regRdata_d[pcie_pkg::BIT_CB_IRQ] = cardIsCardbus
                                                                && !cb_irq_request_n;  // RQ6
                        end
                        default: regRdata_d = '0;
                    endcase
                end
                default: regRdata_d = '0;
            endcase
        end
    end

    // all state registers
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            genCtl_q    <= pcie_pkg::RST_BYTE;
            statFlags_q <= '0;
            statCfg_q   <= pcie_pkg::RST_BYTE;
            ioOfsHigh_q <= pcie_pkg::RST_BYTE;
            cardCtl_q   <= pcie_pkg::RST_BYTE;
            devCtl_q    <= pcie_pkg::RST_BYTE;
            sockEvent_q <= '0;
            sockMask_q  <= '0;
            linePrev_q  <= '0;
            primed_q    <= 1'b0;
            regRdata_q  <= '0;
            irqOut_q    <= '0;
            irqOe_q     <= '0;
            serial_q    <= '0;
        end else begin
            genCtl_q    <= genCtl_d;
            statFlags_q <= statFlags_d;
            statCfg_q   <= statCfg_d;
            ioOfsHigh_q <= ioOfsHigh_d;
            cardCtl_q   <= cardCtl_d;
            devCtl_q    <= devCtl_d;
            sockEvent_q <= sockEvent_d;
            sockMask_q  <= sockMask_d;
            linePrev_q  <= lineNow;
            primed_q    <= 1'b1;
            regRdata_q  <= regRdata_d;
            irqOut_q    <= irqOut_d;
            irqOe_q     <= irqOe_d;
            serial_q    <= serial_d;
        end
    end

    // checks
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rstn);

    a_bvd_change_flag: assert property (primed_q && !cardIsCardbus && !isIo  // RQ1
        && (battery_detect_two != linePrev_q[1]) |=> statFlags_q[1])
        else $error("battery change not flagged");
    a_ready_change: assert property (primed_q && !cardIsCardbus && !isIo  // RQ2
        && (cardReady != linePrev_q[2]) |=> statFlags_q[2])
        else $error("ready change not flagged");
    a_cb_event_w1c: assert property (regRead && regSpace == pcie_pkg::SPACE_SOCKET  // RQ13
        && !regWrite && sockEvent_q[0] |=> sockEvent_q[0])
        else $error("cardbus flag cleared by read");
    a_read_clear: assert property (rdCard && regAddr == pcie_pkg::OFS_STAT_FLAGS  // RQ12
        && !ioOfsHigh_q[2] && flagSet == '0 |=> statFlags_q == '0)
        else $error("flags not cleared by read");
    a_power_done: assert property ($rose(powerUpDone) |=> sockEvent_q[3])  // RQ7
        else $error("power complete not flagged");
    a_detect_flag: assert property (primed_q && (card_detect_one_n != linePrev_q[4])  // RQ8
        |=> statFlags_q[3] && sockEvent_q[1])
        else $error("card detect not flagged");
    a_isa_float: assert property (irqOe_q[9] |-> $past(mode) == pcie_pkg::MODE_ISA  // RQ17
        && $past(fieldsOk))
        else $error("isa pin driven without valid routing");
    a_isa_valid_pin: assert property (mode == pcie_pkg::MODE_ISA && fieldsOk  // RQ15
        && !cardCtl_q[5] |=> irqOut_q == $past(isaLevels))
        else $error("isa levels mismatch");
    a_pci_od: assert property (cardCtl_q[5] && pciAssert |=> irqOe_q[PCI_PIN]  // RQ21
        && !irqOut_q[PCI_PIN])
        else $error("pci line not pulled low");
    a_func_present: assert property (cardIsCardbus && !cb_irq_request_n && regRead  // RQ6
        && regSpace == pcie_pkg::SPACE_SOCKET && regAddr == pcie_pkg::OFS_SOCK_PRESENT
        |=> regRdata_q[6])
        else $error("cardbus interrupt not reported");
    a_io_status_flag: assert property (primed_q && !cardIsCardbus && isIo  // RQ3
        && linePrev_q[0] && !battery_detect_one |=> statFlags_q[pcie_pkg::BIT_BVD_ONE])
        else $error("io status change not flagged");
    a_io_func_pin: assert property (mode == pcie_pkg::MODE_ISA && fieldsOk && isIo  // RQ4
        && !cardIsCardbus && !card_irq_request_n && !cardCtl_q[pcie_pkg::BIT_PCI_EN]
        |=> (irqOut_q & $past(funcPin)) == $past(funcPin))
        else $error("io request not on its pin");
    a_cb_status_flag: assert property (primed_q && cardIsCardbus && !linePrev_q[3]  // RQ5
        && cb_status_change_line |=> sockEvent_q[pcie_pkg::BIT_CB_STATUS])
        else $error("cardbus status change not flagged");
    a_w1c_keep: assert property (rdCard && regAddr == pcie_pkg::OFS_STAT_FLAGS  // RQ12
        && !regWrite && ioOfsHigh_q[pcie_pkg::BIT_CLR_W1C]
        |=> (statFlags_q & $past(statFlags_q)) == $past(statFlags_q))
        else $error("flags cleared by read in write-one mode");
    a_irq_release: assert property (mode == pcie_pkg::MODE_ISA && fieldsOk && !chgPend  // RQ25
        && !funcPend && !cardCtl_q[pcie_pkg::BIT_PCI_EN] |=> irqOut_q == '0)
        else $error("isa pin held without pending flag");
    a_serial_float: assert property (mode == pcie_pkg::MODE_SERIAL  // RQ23
        && !cardCtl_q[pcie_pkg::BIT_PCI_EN] |=> irqOe_q == '0)
        else $error("isa pins driven in serialized mode");
    a_pci_release: assert property (cardCtl_q[pcie_pkg::BIT_PCI_EN] && !pciAssert  // RQ21
        |=> !irqOe_q[PCI_PIN])
        else $error("pci line held without request");

    c_isa_irq: cover property (irqOe_q[1] && irqOut_q[1]);
    c_io_flag: cover property (isIo && statFlags_q[pcie_pkg::BIT_BVD_ONE]);
    c_pci_irq: cover property (cardCtl_q[5] && irqOe_q[PCI_PIN]);
    c_insert: cover property (sockEvent_q[1] && statFlags_q[3]);
    c_serial: cover property (serial_q != '0);

endmodule

// file: pcie_socket_model.sv
// Purpose: card socket and host pin view facing the event block
// Assumes: card lines change just after a rising clock edge
// Notes:   undriven irq pins read high through board pull-ups
`timescale 1ns/100ps
module pcie_socket_model (
    // clock
    input  wire logic       core_clk,
    // card lines toward the block
    output logic            cardIsCardbus,
    output logic            battery_detect_one,
    output logic            battery_detect_two,
    output logic            cardReady,
    output logic            card_irq_request_n,
    output logic            cb_status_change_line,
    output logic            cb_irq_request_n,
    output logic            card_detect_one_n,
    output logic            card_detect_two_n,
    output logic            powerUpDone,
    // pins from the block
    input  wire logic [9:0] irqOut,
    input  wire logic [9:0] irqOe,
    // levels seen by the host controller
    output logic [9:0]      pinLevel
);
    logic [9:0] lines = 10'h05E;  // card seated, all lines idle
    // line vector fanned out to the card pins
    assign cardIsCardbus         = lines[0];
    assign battery_detect_one    = lines[1];
    assign battery_detect_two    = lines[2];
    assign cardReady             = lines[3];
    assign card_irq_request_n    = lines[4];
    assign cb_status_change_line = lines[5];
    assign cb_irq_request_n      = lines[6];
    assign card_detect_one_n     = lines[7];
    assign card_detect_two_n     = lines[8];
    assign powerUpDone           = lines[9];
    // driven pins show their value, released pins float high
    assign pinLevel = (irqOe & irqOut) | ~irqOe;
    // one card line changed just after a clock edge
    task automatic setLine(input int idx, input logic v);
        @(posedge core_clk);
        lines[idx] <= v;
    endtask
endmodule

// file: pcie_events_tb.sv
// Purpose: self-checking bench for the socket interrupt event block
// Assumes: socket A pin arrangement, read-clear mode after reset
// Notes:   each test is a sequence of register and card line steps
`timescale 1ns/100ps
module pcie_events_tb;
    // space selectors and card line indexes
    localparam logic [1:0] CRD = pcie_pkg::SPACE_CARD;
    localparam logic [1:0] CFG = pcie_pkg::SPACE_CONFIG;
    localparam logic [1:0] SCK = pcie_pkg::SPACE_SOCKET;
    localparam int CB = 0, B1 = 1, B2 = 2, RDY = 3, IRQ = 4;
    localparam int SCH = 5, CBI = 6, DT1 = 7, DT2 = 8, PWR = 9;
    // clock, reset and register port
    logic        core_clk, rstn, regWrite, regRead;
    logic [1:0]  regSpace;
    logic [7:0]  regAddr;
    logic [31:0] regWdata, regRdata;
    // card lines from the socket model
    logic cardIsCardbus, battery_detect_one, battery_detect_two, cardReady;
    logic card_irq_request_n, cb_status_change_line, cb_irq_request_n;
    logic card_detect_one_n, card_detect_two_n, powerUpDone;
    // pin side
    logic [9:0]  irqOut, irqOe, pinLevel;
    logic [15:0] serialIrqLevel;
    int          fails = 0;
    int          n_checks = 0;
    // block under test, status alias input unused
    pcie_events #(.PCI_PIN(0)) dut (.core_clk, .rstn, .regWrite, .regRead, .regSpace,
        .regAddr, .regWdata, .regRdata, .cardIsCardbus, .battery_detect_one,
        .battery_detect_two, .cardReady, .card_status_change_n(1'b1), .card_irq_request_n,
        .cb_status_change_line, .cb_irq_request_n, .card_detect_one_n, .card_detect_two_n,
        .powerUpDone, .irqOut, .irqOe, .serialIrqLevel);
    // far side: card socket and host pins
    pcie_socket_model sock (.core_clk, .cardIsCardbus, .battery_detect_one,
        .battery_detect_two, .cardReady, .card_irq_request_n, .cb_status_change_line,
        .cb_irq_request_n, .card_detect_one_n, .card_detect_two_n, .powerUpDone,
        .irqOut, .irqOe, .pinLevel);
    // 25 MHz clock
    initial begin
        core_clk = 1'b0;
        forever #20 core_clk = ~core_clk;
    end
    // register value comparison
    task automatic chkReg(input string n, input logic [7:0] e, input logic [31:0] g);
        n_checks++;
        if (g !== {24'h00_0000, e}) begin
            fails++;
            $display("[ERR] %s exp=%h got=%h", n, {24'h00_0000, e}, g);
        end
    endtask
    // pin vector comparison
    task automatic chkPin(input string n, input logic [15:0] e, input logic [15:0] g);
        n_checks++;
        if (g !== e) begin
            fails++;
            $display("[ERR] %s exp=%h got=%h", n, e, g);
        end
    endtask
    // pin views: enables, values, host levels
    task automatic oe(input logic [9:0] e);
        chkPin("irqOe", {6'h00, e}, {6'h00, irqOe});
    endtask
    task automatic ot(input logic [9:0] e);
        chkPin("irqOut", {6'h00, e}, {6'h00, irqOut});
    endtask
    task automatic lv(input logic [9:0] e);
        chkPin("pinLevel", {6'h00, e}, {6'h00, pinLevel});
    endtask
    // one write, strobe high for a single edge
    task automatic wr(input logic [1:0] s, input logic [7:0] a, input logic [7:0] d);
        @(posedge core_clk);
        regWrite <= 1'b1;
        regSpace <= s;
        regAddr  <= a;
        regWdata <= {24'h00_0000, d};
        @(posedge core_clk);
        regWrite <= 1'b0;
    endtask
    // one read, data registered at the sampling edge
    task automatic rd(input logic [1:0] s, input logic [7:0] a, output logic [31:0] q);
        @(posedge core_clk);
        regRead  <= 1'b1;
        regSpace <= s;
        regAddr  <= a;
        @(posedge core_clk);
        regRead <= 1'b0;
        #1;
        q = regRdata;
    endtask
    // read and compare
    task automatic rc(input logic [1:0] s, input logic [7:0] a, input logic [7:0] e);
        logic [31:0] q;
        rd(s, a, q);
        chkReg($sformatf("reg %0h.%0h", s, a), e, q);
    endtask
    // change selected bits, keep the rest
    task automatic rmw(input logic [1:0] s, input logic [7:0] a, input logic [7:0] m,
                       input logic [7:0] v);
        logic [31:0] q;
        rd(s, a, q);
        wr(s, a, (q[7:0] & ~m) | v);
    endtask
    // flag then pins settle within two edges
    task automatic settle();
        repeat (3) @(posedge core_clk);
        #1;
    endtask
    task automatic ev(input int i, input logic v);
        sock.setLine(i, v);
        settle();
    endtask
    task automatic done(input string n);
        $display("test %s finished", n);
    endtask
    // verdict and end of run
    task automatic summarize();
        $display("checks=%0d fails=%0d", n_checks, fails);
        if (fails == 0 && n_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    // hang guard
    initial begin
        repeat (20000) @(posedge core_clk);
        fails++;
        $display("[ERR] run exp=finished got=timeout");
        summarize();
    end
    // main sequence
    initial begin
        rstn = 1'b0;
        regWrite = 1'b0;
        regRead = 1'b0;
        regSpace = 2'h0;
        regAddr = 8'h00;
        regWdata = 32'h0000_0000;
        repeat (10) @(posedge core_clk);
        rstn <= 1'b1;
        settle();
        rc(CRD, 8'h04, 8'h00);
        wr(CRD, 8'h10, 8'hFF);
        rc(CRD, 8'h10, 8'h00);
        oe(10'h000);
        done("reset");
        wr(CFG, 8'h92, 8'h02);
        settle();
        oe(10'h000);
        wr(CRD, 8'h05, 8'h51);
        settle();
        oe(10'h3FF);
        ev(B1, 1'b0);
        ot(10'h004);
        rc(CRD, 8'h04, 8'h01);
        settle();
        ot(10'h000);
        rc(CRD, 8'h04, 8'h00);
        ev(B2, 1'b0);
        ot(10'h000);
        rc(CRD, 8'h04, 8'h02);
        done("battery");
        rmw(CRD, 8'h1E, 8'h04, 8'h04);
        ev(RDY, 1'b0);
        rc(CRD, 8'h04, 8'h04);
        rc(CRD, 8'h04, 8'h04);
        wr(CRD, 8'h04, 8'h04);
        rc(CRD, 8'h04, 8'h00);
        done("ready");
        ev(DT1, 1'b1);
        rc(CRD, 8'h04, 8'h08);
        rc(SCK, 8'h00, 8'h02);
        wr(SCK, 8'h04, 8'h04);
        ev(DT2, 1'b1);
        rc(SCK, 8'h00, 8'h06);
        ot(10'h004);
        wr(SCK, 8'h00, 8'h06);
        wr(CRD, 8'h04, 8'h08);
        settle();
        ot(10'h000);
        rc(SCK, 8'h00, 8'h00);
        done("detect");
        wr(CRD, 8'h03, 8'h29);
        ev(IRQ, 1'b0);
        ot(10'h010);
        rc(CFG, 8'h91, 8'h01);
        ev(IRQ, 1'b1);
        ot(10'h000);
        ev(B1, 1'b1);
        rc(CRD, 8'h04, 8'h00);
        ev(B1, 1'b0);
        ot(10'h004);
        wr(CRD, 8'h04, 8'h01);
        wr(CRD, 8'h05, 8'h61);
        settle();
        oe(10'h000);
        wr(CRD, 8'h05, 8'h51);
        done("io card");
        wr(CRD, 8'h03, 8'h09);
        ev(CB, 1'b1);
        ev(SCH, 1'b1);
        rc(SCK, 8'h00, 8'h01);
        rc(SCK, 8'h00, 8'h01);
        ot(10'h000);
        wr(SCK, 8'h04, 8'h09);
        settle();
        ot(10'h004);
        wr(SCK, 8'h00, 8'h01);
        ev(PWR, 1'b1);
        rc(SCK, 8'h00, 8'h08);
        wr(SCK, 8'h00, 8'h08);
        settle();
        ot(10'h000);
        ev(CBI, 1'b0);
        rc(SCK, 8'h08, 8'h40);
        ot(10'h010);
        done("cardbus");
        wr(CFG, 8'h91, 8'hFF);
        rc(CFG, 8'h91, 8'h39);
        settle();
        oe(10'h3FF);
        lv(10'h010);
        ev(CBI, 1'b1);
        oe(10'h3FE);
        lv(10'h001);
        ev(SCH, 1'b0);
        ev(SCH, 1'b1);
        oe(10'h3FF);
        lv(10'h004);
        wr(SCK, 8'h00, 8'h01);
        done("pci");
        wr(CFG, 8'h91, 8'h00);
        rmw(CFG, 8'h92, 8'h06, 8'h04);
        ev(SCH, 1'b0);
        ev(SCH, 1'b1);
        oe(10'h000);
        chkPin("serialIrqLevel", 16'h0020, serialIrqLevel);
        wr(SCK, 8'h00, 8'h01);
        settle();
        chkPin("serialIrqLevel", 16'h0000, serialIrqLevel);
        done("serial");
        summarize();
    end
endmodule
